// File: pci_host_model.sv
// Purpose: Bus master model, one transfer per call of xfer.
// Assumes: Drives on the falling edge of mclk.
// Notes: Flag bits: bad address parity, bad data parity, burst, keep bus.
`timescale 1ns/1ps
module pci_host_model
(
  input  wire logic        mclk,
  input  wire logic        devsel_n,
  input  wire logic        trdy_n,
  input  wire logic        stop_n,
  input  wire logic [31:0] ad_out,
  output logic             frame_n,
  output logic             irdy_n,
  output logic             idsel,
  output logic [3:0]       cbe_n,
  output logic [31:0]      ad_in,
  output logic             par_in
);
  logic [31:0] rd_q;
  logic        done_q, stop_q;
  initial {frame_n, irdy_n, idsel, cbe_n, ad_in, par_in} = {3'b110, 4'hf, 32'h0, 1'b0};
  task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] a, wd,
                      input logic [3:0] fl);
    {frame_n, irdy_n, idsel, cbe_n, ad_in, par_in} = {2'b01, sel, cmd, a, ^{a, cmd} ^ fl[0]};
    @(negedge mclk);
    {frame_n, irdy_n, idsel, cbe_n, ad_in} = {~fl[2], 2'b00, 4'he, wd};
    par_in = ^{wd, 4'he} ^ fl[1];
    done_q = 1'b0;
    for (int n = 0; n < 120 && !done_q && !(n > 12 && devsel_n); n++)
      @(negedge mclk) {done_q, stop_q, rd_q} = {!trdy_n, !stop_n, ad_out};
    // Irdy stays low across the edge that samples trdy, or the target could miss it.
    @(negedge mclk);
    if (!fl[3])
      {frame_n, irdy_n, cbe_n, ad_in, par_in} = {2'b11, ~cbe_n, ~ad_in, ~par_in};
  endtask
endmodule

// File: pci_target_pkg.sv
// Purpose: Constants and carrier types for the expansion bus target port.
// Assumes: Single clock mclk at 25 MHz; bus pins arrive already in this domain's timing.
// Notes: Functional notes below.
// Functional notes
// - Only 32-bit addresses are decoded and only 32-bit data moves; no 64-bit path exists.
// - A narrow read still returns the whole 32-bit word of the addressed location.
// - A narrow write stores all 32 data bits, disregarding the byte enables.
// - Memory read, memory write, configuration read and configuration write are served, one data phase each.
// - A burst attempt is ended with a target disconnect so that one data phase completes.
// - A read not serviced within 32 system clocks completes with all-ones data.
// - Read timeout raises no interrupt and no bus error; only the data shows it.
// - The read timeout can be switched off, so reads wait without limit.
// - Fast back-to-back transactions are accepted without an idle cycle between them.
// - Bad address parity on a claimed transaction asserts the system error output.
// - Bad data parity on a target write asserts the parity error output.
// - Accesses reach on-chip registers, on-chip memory and external packet memory via the memory unit.
// - The bus runs at a 33 MHz clock with a 32-bit multiplexed address and data path; the bench clocks the bus on mclk at 25 MHz.
package pci_target_pkg;

  localparam int          BUS_W         = 32;
  localparam logic [3:0]  CMD_MEM_RD    = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR    = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD    = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR    = 4'hb;
  localparam int          RD_TIMEOUT_CYC = 32;
  localparam logic [5:0]  RD_TIMEOUT_MAX = 6'h20;
  localparam logic [31:0] TIMEOUT_DATA  = 32'hffffffff;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_DATA = 2'b11,
    S_TURN = 2'b10
  } tgt_state_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        cfg_space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } back_req_t;

endpackage

// File: pci_target_slave_port.sv
// Purpose: Target side of the 32-bit expansion bus, one data phase per transaction.
// Assumes: Bus pins are sampled on mclk; the back end answers with a one-cycle ack.
// Notes: Pins named *_n are active low; output enables are high while driving.
`timescale 1ns/1ps
module pci_target_slave_port
  import pci_target_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        idsel,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [31:0] ad_in,
  input  wire logic        par_in,
  input  wire logic        timeout_en,
  input  wire logic        bar_hit,
  output logic [31:0]      ad_out,
  output logic             ad_oe,
  output logic             par_out,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             stop_n,
  output logic             ctl_oe,
  output logic             perr_n,
  output logic             perr_oe,
  output logic             serr_n,
  output logic             serr_oe,
  output back_req_t        back_req,
  input  wire logic        back_ack,
  input  wire logic [31:0] back_rdata
);

  logic        frame_s1, frame_s2, irdy_s1, irdy_s2, idsel_s1, idsel_s2, par_s1, par_s2;
  logic [3:0]  cbe_s1, cbe_s2;
  logic [31:0] ad_s1, ad_s2;
  logic        frame_d_r;
  tgt_state_t  state_r;
  logic [5:0]  wait_cnt_r;
  logic        wr_r;
  logic        par_chk_r;
  logic        addr_phase, cmd_ok, claim, addr_par_bad;

  // Two-stage capture of every bus input before any decode looks at it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      frame_s1 <= 1'b1;
      frame_s2 <= 1'b1;
      irdy_s1  <= 1'b1;
      irdy_s2  <= 1'b1;
      idsel_s1 <= 1'b0;
      idsel_s2 <= 1'b0;
      par_s1   <= 1'b0;
      par_s2   <= 1'b0;
      cbe_s1   <= 4'hf;
      cbe_s2   <= 4'hf;
      ad_s1    <= 32'h00000000;
      ad_s2    <= 32'h00000000;
    end
    else
    begin
      frame_s1 <= frame_n;
      frame_s2 <= frame_s1;
      irdy_s1  <= irdy_n;
      irdy_s2  <= irdy_s1;
      idsel_s1 <= idsel;
      idsel_s2 <= idsel_s1;
      par_s1   <= par_in;
      par_s2   <= par_s1;
      cbe_s1   <= cbe_n;
      cbe_s2   <= cbe_s1;
      ad_s1    <= ad_in;
      ad_s2    <= ad_s1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      frame_d_r <= 1'b1;
    else
      frame_d_r <= frame_s2;
  end

  // An address phase is a falling frame, or frame held low across a finished
  // transaction, which is how a fast back-to-back cycle arrives.
  always_comb
  begin
    addr_phase = !frame_s2 && (frame_d_r || (state_r == S_TURN));
    cmd_ok = (cbe_s2 == CMD_MEM_RD) || (cbe_s2 == CMD_MEM_WR) ||
             ((cbe_s2 == CMD_CFG_RD || cbe_s2 == CMD_CFG_WR) && idsel_s2);
    claim = addr_phase && (state_r == S_IDLE || state_r == S_TURN)
            && cmd_ok && (bar_hit || idsel_s2);
    addr_par_bad = (^{ad_s2, cbe_s2}) != par_s2;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= S_IDLE;
      wr_r     <= 1'b0;
      back_req <= '0;
    end
    else
    begin
      back_req.req <= 1'b0;
      unique case (state_r)
        S_IDLE, S_TURN:
        begin
          if (claim)
          begin
            state_r         <= S_WAIT;
            wr_r            <= cbe_s2[0];
            back_req.write  <= cbe_s2[0];
            back_req.cfg_space <= cbe_s2[3];
            back_req.addr   <= ad_s2;
          end
          else
            state_r <= S_IDLE;
        end
        S_WAIT:
        begin
          if (!irdy_s2)
          begin
            // The whole word is stored; byte enables are not looked at.
            back_req.req   <= 1'b1;
            back_req.wdata <= ad_s2;
            state_r        <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (back_ack || (timeout_en && wait_cnt_r == RD_TIMEOUT_MAX - 6'h01 && !wr_r))
            state_r <= S_TURN;
        end
      endcase
    end
  end

  // Read wait counter; the limit holds only while the timeout is enabled.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wait_cnt_r <= 6'h00;
    else if (state_r == S_DATA)
      wait_cnt_r <= wait_cnt_r + 6'h01;
    else
      wait_cnt_r <= 6'h00;
  end

  // Completion: one data phase, with stop asserted so any burst is disconnected.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      devsel_n     <= 1'b1;
      trdy_n       <= 1'b1;
      stop_n       <= 1'b1;
      ctl_oe       <= 1'b0;
      ad_out       <= 32'h00000000;
      ad_oe        <= 1'b0;
      par_out      <= 1'b0;
    end
    else
    begin
      devsel_n <= !(state_r == S_WAIT || state_r == S_DATA);
      ctl_oe   <= (state_r != S_IDLE);
      trdy_n   <= 1'b1;
      stop_n   <= 1'b1;
      ad_oe    <= 1'b0;
      if (state_r == S_DATA && back_ack)
      begin
        trdy_n       <= 1'b0;
        stop_n       <= 1'b0;
        devsel_n     <= 1'b0;
        ad_out       <= back_rdata;
        ad_oe        <= !wr_r;
      end
      else if (state_r == S_DATA && timeout_en && !wr_r
               && wait_cnt_r == RD_TIMEOUT_MAX - 6'h01)
      begin
        trdy_n       <= 1'b0;
        stop_n       <= 1'b0;
        devsel_n     <= 1'b0;
        ad_out       <= TIMEOUT_DATA;
        ad_oe        <= 1'b1;
      end
      par_out <= ^{ad_out, 4'h0};
    end
  end

  // Parity reporting, driven low only for one cycle per event.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      serr_n    <= 1'b1;
      serr_oe   <= 1'b0;
      perr_n    <= 1'b1;
      perr_oe   <= 1'b0;
      par_chk_r <= 1'b0;
    end
    else
    begin
      serr_n    <= !(claim && addr_par_bad);
      serr_oe   <= claim && addr_par_bad;
      par_chk_r <= (state_r == S_WAIT) && !irdy_s2 && wr_r;
      perr_n    <= !(par_chk_r && ((^{back_req.wdata, cbe_s2}) != par_s2));
      perr_oe   <= (state_r == S_DATA) || !perr_n;
    end
  end

  a_serr_on_badpar: assert property (@(posedge mclk) disable iff (rst)
    (claim && addr_par_bad) |=> !serr_n) else $error("serr missing on address parity");
  a_one_phase_stop: assert property (@(posedge mclk) disable iff (rst)
    !trdy_n |-> !stop_n) else $error("data phase without disconnect");
  a_timeout_ones: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA && !wr_r && timeout_en && !back_ack && wait_cnt_r == 6'h1f)
    |=> (ad_out == TIMEOUT_DATA && !trdy_n)) else $error("timeout data wrong");
  a_timeout_bound: assert property (@(posedge mclk) disable iff (rst)
    (timeout_en && !wr_r && state_r == S_DATA) |-> wait_cnt_r <= 6'h1f)
    else $error("read wait exceeded limit");
  a_no_serr_timeout: assert property (@(posedge mclk) disable iff (rst)
    (!trdy_n && ad_out == TIMEOUT_DATA && !$past(back_ack)) |-> serr_n)
    else $error("timeout raised error");
  a_no_limit_off: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA && !timeout_en && !back_ack) |=> state_r == S_DATA)
    else $error("read ended without data while timeout off");
  a_unclaimed_cmd: assert property (@(posedge mclk) disable iff (rst)
    (addr_phase && !cmd_ok) |=> state_r != S_WAIT) else $error("bad command claimed");
  a_full_write: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_WAIT && !irdy_s2) |=> (back_req.req && back_req.wdata == $past(ad_s2)))
    else $error("write word not stored whole");
  a_read_word: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA && back_ack && !wr_r) |=> (ad_oe && ad_out == $past(back_rdata)))
    else $error("read word not driven");
  a_fast_b2b: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_TURN && claim) |=> state_r == S_WAIT) else $error("back-to-back missed");

  // Claim and completion timing, counted from the synchronised address phase.
  a_devsel_cmd: assert property (@(posedge mclk) disable iff (rst)
    claim |-> ##2 !devsel_n)
    else $error("claimed cycle without devsel");

  a_no_devsel_io: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_IDLE && addr_phase && !cmd_ok) |-> ##2 devsel_n)
    else $error("devsel on unserved command");

  a_stop_once: assert property (@(posedge mclk) disable iff (rst)
    !stop_n |=> stop_n)
    else $error("stop held beyond one phase");

  a_ad_oe_read: assert property (@(posedge mclk) disable iff (rst)
    ad_oe |-> !wr_r)
    else $error("data driven during write");

  a_ctl_oe_claim: assert property (@(posedge mclk) disable iff (rst)
    !devsel_n |-> ctl_oe)
    else $error("devsel low without enable");

  a_trdy_after_ack: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA && back_ack) |=> !trdy_n)
    else $error("ack not completed");

  a_wait_to_req: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_WAIT && !irdy_s2) |=> state_r == S_DATA)
    else $error("data phase not taken");

  a_cfg_needs_sel: assert property (@(posedge mclk) disable iff (rst)
    (claim && cbe_s2[3]) |-> idsel_s2)
    else $error("config claimed without select");

  a_req_pulse: assert property (@(posedge mclk) disable iff (rst)
    back_req.req |=> !back_req.req)
    else $error("back end request too long");

  a_write_no_tmo: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA && wr_r && !back_ack) |=> state_r == S_DATA)
    else $error("write ended without ack");

  a_perr_on_bad: assert property (@(posedge mclk) disable iff (rst)
    (par_chk_r && ((^{back_req.wdata, cbe_s2}) != par_s2)) |=> (!perr_n && perr_oe))
    else $error("perr missing on data parity");

  a_serr_oe_pair: assert property (@(posedge mclk) disable iff (rst)
    !serr_n |-> serr_oe)
    else $error("serr low without enable");

  a_no_serr_idle: assert property (@(posedge mclk) disable iff (rst)
    !claim |=> serr_n)
    else $error("serr without claimed cycle");

  a_turn_idle: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_TURN && !claim) |=> state_r == S_IDLE)
    else $error("turn state not left");

  a_tmo_count: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA) |=> (state_r != S_DATA || wait_cnt_r == $past(wait_cnt_r) + 6'h01))
    else $error("read wait count skipped");

endmodule

// File: pci_target_slave_port_bench.sv
// Purpose: Self-checking bench for the expansion bus target port.
// Assumes: The host model drives the bus; the bench acts as back end.
// Notes: The back end acks ack_delay cycles after a request; zero never acks.
`timescale 1ns/1ps
module pci_target_slave_port_bench;
  import pci_target_pkg::*;
  logic        mclk = 1'b0, back_ack = 1'b0;
  logic        rst, frame_n, irdy_n, idsel, par_in, timeout_en, bar_hit, ad_oe, par_out;
  logic        devsel_n, trdy_n, stop_n, ctl_oe, perr_n, perr_oe, serr_n, serr_oe;
  logic [3:0]  cbe_n;
  logic [1:0]  oe_seen;
  logic [31:0] ad_in, ad_out, rd_word, back_rdata = 32'h0;
  back_req_t   back_req, got;
  int          bad_count, samples_checked, ack_delay, ack_cnt;
  int          req_cnt, serr_cnt, perr_cnt, n0, s0, p0;
  pci_target_slave_port i_pci_target_slave_port (.mclk, .rst, .frame_n, .irdy_n, .idsel,
    .cbe_n, .ad_in, .par_in, .timeout_en, .bar_hit, .ad_out, .ad_oe, .par_out, .devsel_n,
    .trdy_n, .stop_n, .ctl_oe, .perr_n, .perr_oe, .serr_n, .serr_oe, .back_req, .back_ack,
    .back_rdata);
  pci_host_model i_pci_host_model (.mclk, .devsel_n, .trdy_n, .stop_n, .ad_out, .frame_n,
    .irdy_n, .idsel, .cbe_n, .ad_in, .par_in);
  initial forever #20 mclk = ~mclk;
  always @(negedge mclk)
  begin
    {back_ack, back_rdata} <= (ack_cnt == 1 && !back_req.req) ? {1'b1, rd_word} : {1'b0, ~rd_word};
    ack_cnt  <= back_req.req ? ack_delay : (ack_cnt > 0 ? ack_cnt - 1 : 0);
    req_cnt  <= req_cnt + int'(back_req.req);
    serr_cnt <= serr_cnt + int'(!serr_n && serr_oe);
    perr_cnt <= perr_cnt + int'(!perr_n && perr_oe);
    if (!trdy_n)
      oe_seen <= {ad_oe, ctl_oe};
    if (back_req.req)
      got <= back_req;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    bad_count += int'(g !== e);
    if (g !== e)
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic go(input logic [3:0] c, input logic s, input logic [31:0] a, w,
                    input logic [3:0] f, input logic claim);
    @(negedge mclk);
    i_pci_host_model.xfer(c, s, a, w, f);
    chk({31'h0, i_pci_host_model.done_q}, {31'h0, claim});
    if (claim && !i_pci_host_model.done_q)
      complete_run();
  endtask
  task automatic s_cmds;
    logic [3:0] cmds [4] = '{CMD_MEM_RD, CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR};
    for (int i = 0; i < 4; i++)
    begin
      go(cmds[i], i[1], 32'h100 + 4 * i, 32'h5a0f3c96 ^ i, 4'h0, 1'b1);
      chk({30'h0, got.cfg_space, got.write}, {30'h0, i[1], i[0]});
      chk({30'h0, oe_seen}, {30'h0, !i[0], 1'b1});
      chk(got.addr, 32'h100 + 4 * i);
      chk(i[0] ? got.wdata : i_pci_host_model.rd_q, i[0] ? 32'h5a0f3c96 ^ i : rd_word);
    end
    $display("cmds done");
  endtask
  task automatic s_skip;
    n0 = req_cnt;
    go(4'h2, 1'b0, 32'h200, 32'h0, 4'h0, 1'b0);
    bar_hit = 1'b0;
    go(CMD_MEM_WR, 1'b0, 32'h200, 32'h0, 4'h0, 1'b0);
    bar_hit = 1'b1;
    chk(req_cnt - n0, 32'h0);
    $display("skip done");
  endtask
  task automatic s_tmo;
    s0 = serr_cnt + perr_cnt;
    {timeout_en, ack_delay} = {1'b1, 32'h0};
    go(CMD_MEM_RD, 1'b0, 32'h300, 32'h0, 4'h0, 1'b1);
    chk(i_pci_host_model.rd_q, TIMEOUT_DATA);
    chk(serr_cnt + perr_cnt - s0, 32'h0);
    {timeout_en, ack_delay} = {1'b0, 32'h2d};
    go(CMD_MEM_RD, 1'b0, 32'h304, 32'h0, 4'h0, 1'b1);
    chk(i_pci_host_model.rd_q, rd_word);
    ack_delay = 3;
    $display("timeout done");
  endtask
  task automatic s_burst;
    n0 = req_cnt;
    go(CMD_MEM_WR, 1'b0, 32'h400, 32'h0f1e2d3c, 4'h4, 1'b1);
    chk({31'h0, i_pci_host_model.stop_q}, 32'h1);
    @(negedge mclk);
    i_pci_host_model.xfer(CMD_MEM_WR, 1'b0, 32'h404, 32'h11223344, 4'h8);
    i_pci_host_model.xfer(CMD_MEM_WR, 1'b0, 32'h408, 32'h55667788, 4'h0);
    chk(got.wdata, 32'h55667788);
    chk(req_cnt - n0, 32'h3);
    $display("burst done");
  endtask
  task automatic s_par;
    for (int f = 0; f < 3; f++)
    begin
      {s0, p0} = {serr_cnt, perr_cnt};
      go(CMD_MEM_WR, 1'b0, 32'h500, 32'h1, f[3:0], 1'b1);
      repeat (3) @(negedge mclk);
      chk({30'h0, perr_cnt != p0, serr_cnt != s0}, {30'h0, f[1:0]});
    end
    $display("parity done");
  endtask
  initial
  begin
    {rst, timeout_en, bar_hit, ack_delay, rd_word} = {3'b101, 32'h3, 32'h13579bdf};
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    s_cmds();
    s_skip();
    s_tmo();
    s_burst();
    s_par();
    complete_run();
  end
endmodule
